// File: rat_agc_time.sv
`timescale 1ns/1ps
`default_nettype none
//==============================================================
// Right-channel AGC timing register bank.
//==============================================================
// Operation
// R1: Attack select 0 legacy, 1 this register.
// R2: Attack baseline codes give 7/8/10/11 ms.
// R3: Attack multiplier scales by two to code.
// R4: Decay select 0 legacy, 1 this register.
// R5: Decay baseline codes give 50/150/250/350 ms.
// R6: Decay multiplier scales by two to code.
// R7: Software writes zero to bits one and zero.
// R8: Decay cap 4/5.6/8/9.6 s for low ratios.
// R9: Decay cap 11.2/16/19.2/22.4 s higher ratios.
// R10: Over-cap decay product uses the cap.
// R11: Both registers reset to zero, legacy source.
module rat_agc_time (
    input  wire logic        clk,                 // 250 MHz core clock.
    input  wire logic        rst_n,               // Asynchronous reset, active low.
    input  wire logic [6:0]  regAddr,             // Register address on page 0.
    input  wire logic        regWrEn,             // Write strobe, one cycle.
    input  wire logic [7:0]  regWrData,           // Write data.
    input  wire logic        regRdEn,             // Read strobe, one cycle.
    input  wire logic [15:0] legacyAttackMs,      // Attack from the legacy register.
    input  wire logic [15:0] legacyDecayMs,       // Decay from the legacy register.
    input  wire logic [3:0]  adcDecimationRatio,  // Twice the decimation ratio.
    output logic      [7:0]  regRdData,           // Read data, valid after the strobe.
    output logic      [15:0] attackMs,            // Effective attack time.
    output logic      [15:0] decayMs,             // Effective decay time.
    output logic             attackFromProg,      // Attack uses programmed fields.
    output logic             decayFromProg        // Decay uses programmed fields.
);

    //==========================================================
    // Register storage.
    //==========================================================
    rat_pkg::rat_timing_t attackReg;       // Attack timing register.
    rat_pkg::rat_timing_t decayReg;        // Decay timing register.
    logic [15:0]          next_attackMs;   // Attack before the output flop.
    logic [15:0]          next_decayMs;    // Decay before the output flop.
    logic [15:0]          decayCapMs;      // Cap for the present ratio.
    logic [15:0]          attackBaseMs;    // Decoded attack baseline.
    logic [15:0]          decayBaseMs;     // Decoded decay baseline.

    // Attack register writes; reserved bits are stored as written.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            attackReg <= rat_pkg::RAT_REG_RESET;  // R11
        end else if (regWrEn && regAddr == rat_pkg::RAT_ADDR_ATTACK) begin
            attackReg <= regWrData;  // R7
        end
    end

    // Decay register writes.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            decayReg <= rat_pkg::RAT_REG_RESET;  // R11
        end else if (regWrEn && regAddr == rat_pkg::RAT_ADDR_DECAY) begin
            decayReg <= regWrData;  // R7
        end
    end

    //==========================================================
    // Read port.
    //==========================================================
    // Reads answer on the next edge; unmapped addresses return zero so
    // that a stray access never shows stale data from a mapped one.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= rat_pkg::RAT_RD_UNMAPPED;
        end else if (regRdEn) begin
            case (regAddr)
                rat_pkg::RAT_ADDR_ATTACK: begin
                    regRdData <= attackReg;
                end
                rat_pkg::RAT_ADDR_DECAY: begin
                    regRdData <= decayReg;
                end
                default: begin
                    regRdData <= rat_pkg::RAT_RD_UNMAPPED;
                end
            endcase
        end
    end

    //==========================================================
    // Time computation.
    //==========================================================
    // The decoded decay baseline and the cap are shared with the checks below.
    always_comb begin
        attackBaseMs = rat_pkg::rat_attack_base(attackReg.base);  // R2
        decayBaseMs  = rat_pkg::rat_decay_base(decayReg.base);    // R5
        decayCapMs   = rat_pkg::rat_decay_cap(adcDecimationRatio);  // R8 R9
    end

    // Attack time; never capped.
    rat_time_calc uAttack (
        .select   (attackReg.select),
        .baseMs   (attackBaseMs),
        .mult     (attackReg.mult),
        .legacyMs (legacyAttackMs),
        .capMs    (rat_pkg::RAT_NO_CAP),
        .timeMs   (next_attackMs)
    );

    // Decay time; the cap also bounds a legacy value, since the limit
    // comes from the decimator and not from the register chosen.
    rat_time_calc uDecay (
        .select   (decayReg.select),
        .baseMs   (decayBaseMs),
        .mult     (decayReg.mult),
        .legacyMs (legacyDecayMs),
        .capMs    (decayCapMs),
        .timeMs   (next_decayMs)
    );

    // Output flops; one cycle of latency keeps the long compare off the AGC.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            attackMs       <= 16'h0000;
            decayMs        <= 16'h0000;
            attackFromProg <= 1'b0;
            decayFromProg  <= 1'b0;
        end else begin
            attackMs       <= next_attackMs;     // R1
            decayMs        <= next_decayMs;      // R4
            attackFromProg <= attackReg.select;  // R1
            decayFromProg  <= decayReg.select;   // R4
        end
    end

    //==========================================================
    // Checks.
    //==========================================================
    logic afterReset;  // Low during reset and in the first cycle after release.

    // Marks the first clocked cycle after reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            afterReset <= 1'b0;
        end else begin
            afterReset <= 1'b1;
        end
    end

    // A write to the attack register followed by a read of it.
    sequence seqAttackWrRd;
        (regWrEn && regAddr == rat_pkg::RAT_ADDR_ATTACK)
        ##1 (regRdEn && !regWrEn && regAddr == rat_pkg::RAT_ADDR_ATTACK);
    endsequence

    AST_ATT_LEGACY: assert property (@(posedge clk) disable iff (!rst_n) // R1
        !attackReg.select |=> attackMs == $past(legacyAttackMs) && !attackFromProg)
        else $error("Attack did not follow the legacy source.");

    AST_ATT_BASE: assert property (@(posedge clk) disable iff (!rst_n) // R2
        (attackReg.select && attackReg.mult == 3'h0 && attackReg.base == 2'h2)
        |=> attackMs == 16'h000A)
        else $error("Attack baseline code two is not 10 ms.");

    AST_ATT_MULT: assert property (@(posedge clk) disable iff (!rst_n) // R3
        (attackReg.select && attackReg.mult == 3'h7 && attackReg.base == 2'h3)
        |=> attackMs == 16'h0580)
        else $error("Attack scaling by 128 is wrong.");

    AST_DEC_LEGACY: assert property (@(posedge clk) disable iff (!rst_n) // R4
        (!decayReg.select && legacyDecayMs <= decayCapMs)
        |=> decayMs == $past(legacyDecayMs) && !decayFromProg)
        else $error("Decay did not follow the legacy source.");

    AST_DEC_SCALE: assert property (@(posedge clk) disable iff (!rst_n) // R5 R6
        (decayReg.select && decayReg.base == 2'h1 && decayReg.mult == 3'h3
         && adcDecimationRatio >= rat_pkg::RAT_RATIO_1_0)
        |=> decayMs == 16'h04B0)
        else $error("Decay 150 ms times 8 is not 1200 ms.");

    AST_DEC_CAP: assert property (@(posedge clk) disable iff (!rst_n) // R8 R9
        ##1 decayMs <= rat_pkg::rat_decay_cap($past(adcDecimationRatio)))
        else $error("Decay exceeds the cap for the ratio.");

    AST_DEC_CLAMP: assert property (@(posedge clk) disable iff (!rst_n) // R10
        (decayReg.select && rat_pkg::rat_scale(decayBaseMs, decayReg.mult) > decayCapMs)
        |=> decayMs == $past(decayCapMs))
        else $error("Over-cap decay did not take the cap.");

    AST_CAP_R3: assert property (@(posedge clk) disable iff (!rst_n) // R9
        (decayReg.select && decayReg.base == 2'h3 && decayReg.mult == 3'h7
         && adcDecimationRatio == rat_pkg::RAT_RATIO_3_5)
        |=> decayMs == 16'h2BC0)
        else $error("Ratio 3.5 cap is not 11.2 s.");

    AST_RESET_ZERO: assert property (@(posedge clk) disable iff (!rst_n) // R11
        !afterReset |-> attackReg == 8'h00 && decayReg == 8'h00 && regRdData == 8'h00)
        else $error("Registers not zero after reset.");

    AST_WR_RD: assert property (@(posedge clk) disable iff (!rst_n) // R7
        seqAttackWrRd |=> regRdData == $past(regWrData, 2))
        else $error("Attack register read-back differs from write.");

    // Source flags are plain registered copies of the select bits.
    AST_ATT_FLAG: assert property (@(posedge clk) disable iff (!rst_n) // R1
        ##1 attackFromProg == $past(attackReg.select))
        else $error("Attack source flag does not follow the select bit.");

    AST_DEC_FLAG: assert property (@(posedge clk) disable iff (!rst_n) // R4
        ##1 decayFromProg == $past(decayReg.select))
        else $error("Decay source flag does not follow the select bit.");

    // Shortest programmed times: baseline code zero with no scaling.
    AST_ATT_BASE0: assert property (@(posedge clk) disable iff (!rst_n) // R2
        (attackReg.select && attackReg.mult == 3'h0 && attackReg.base == 2'h0)
        |=> attackMs == 16'h0007)
        else $error("Attack baseline code zero is not 7 ms.");

    AST_DEC_BASE0: assert property (@(posedge clk) disable iff (!rst_n) // R5
        (decayReg.select && decayReg.mult == 3'h0 && decayReg.base == 2'h0)
        |=> decayMs == 16'h0032)
        else $error("Decay baseline code zero is not 50 ms.");

    // A read returns the value held before any write in the same cycle.
    AST_RD_DECAY: assert property (@(posedge clk) disable iff (!rst_n) // R4
        (regRdEn && regAddr == rat_pkg::RAT_ADDR_DECAY)
        |=> regRdData == $past(decayReg))
        else $error("Decay register read-back differs from its contents.");

endmodule : rat_agc_time
`default_nettype wire

// File: rat_agc_time_tb.sv
`timescale 1ns/1ps
`default_nettype none
//==============================================================
// Self-checking bench for the right-channel AGC timing bank.
//==============================================================
module rat_agc_time_tb;
    logic        clk;                 // Core clock.
    logic        rst_n;               // Reset, active low.
    logic [6:0]  regAddr;             // Host address.
    logic        regWrEn;             // Host write strobe.
    logic [7:0]  regWrData;           // Host write data.
    logic        regRdEn;             // Host read strobe.
    logic [15:0] legacyAttackMs;      // Legacy attack time.
    logic [15:0] legacyDecayMs;       // Legacy decay time.
    logic [3:0]  adcDecimationRatio;  // Twice the ratio.
    logic [7:0]  regRdData;           // Read data.
    logic [15:0] attackMs;            // Effective attack.
    logic [15:0] decayMs;             // Effective decay.
    logic        attackFromProg;      // Attack source flag.
    logic        decayFromProg;       // Decay source flag.
    int          badCount;            // Mismatches seen.
    int          compares;            // Comparisons made.
    int          seed;                // Random seed.
    logic [7:0]  ra;                  // Attack register image.
    logic [7:0]  rd;                  // Decay register image.

    rat_agc_time dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .legacyAttackMs(legacyAttackMs),
        .legacyDecayMs(legacyDecayMs), .adcDecimationRatio(adcDecimationRatio),
        .regRdData(regRdData), .attackMs(attackMs), .decayMs(decayMs),
        .attackFromProg(attackFromProg), .decayFromProg(decayFromProg));
    rat_host_model host (.clk(clk), .regRdData(regRdData), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn));

    // Free-running 250 MHz clock.
    always #2 clk = ~clk;

    // Reference time from integers; the cap applies to decay only.
    function automatic int model_time(input logic [7:0] r, input int legacy, input bit dec,
                                      input int ratio);
        int base;
        int t;
        int cap;
        if (dec) begin
            base = (r[6:5] == 0) ? 50 : (r[6:5] == 1) ? 150 : (r[6:5] == 2) ? 250 : 350;
        end else begin
            base = (r[6:5] == 0) ? 7 : (r[6:5] == 1) ? 8 : (r[6:5] == 2) ? 10 : 11;
        end
        t   = r[7] ? (base << r[4:2]) : legacy;
        cap = (ratio <= 2) ? 4000 : (ratio == 3) ? 5600 : (ratio == 4) ? 8000 :
              (ratio == 5) ? 9600 : (ratio <= 7) ? 11200 : (ratio <= 9) ? 16000 :
              (ratio == 10) ? 19200 : 22400;
        model_time = (dec && t > cap) ? cap : t;
    endfunction : model_time

    // Compare of a byte result.
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            badCount++;
        end
    endtask : chk_reg

    // Compare of a time result.
    task automatic chk_time(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            badCount++;
        end
    endtask : chk_time

    // Let outputs settle, then read back and check every result.
    task automatic check_all;
        logic [7:0] got;
        @(negedge clk);
        @(negedge clk);
        chk_time(attackMs, 16'(model_time(ra, legacyAttackMs, 0, 0)));
        chk_time(decayMs, 16'(model_time(rd, legacyDecayMs, 1, adcDecimationRatio)));
        chk_reg({7'h00, attackFromProg}, {7'h00, ra[7]});
        chk_reg({7'h00, decayFromProg}, {7'h00, rd[7]});
        host.read_reg(rat_pkg::RAT_ADDR_ATTACK, got);
        chk_reg(got, {ra[7:2], 2'h0});
        host.read_reg(rat_pkg::RAT_ADDR_DECAY, got);
        chk_reg(got, {rd[7:2], 2'h0});
        host.read_reg(7'h6B, got);
        chk_reg(got, 8'h00);
    endtask : check_all

    // Program both registers and the inputs, then check.
    task automatic apply(input logic [7:0] a, input logic [7:0] d, input logic [3:0] ratio);
        logic [7:0] got;
        @(negedge clk);
        legacyAttackMs     = 16'($random(seed));
        legacyDecayMs      = 16'($random(seed));
        adcDecimationRatio = ratio;
        ra = {a[7:2], 2'h0};
        rd = {d[7:2], 2'h0};
        host.write_then_read(rat_pkg::RAT_ADDR_ATTACK, ra, got);
        chk_reg(got, ra);
        host.write_reg(rat_pkg::RAT_ADDR_DECAY, rd);
        check_all();
    endtask : apply

    // Verdict and end of the run.
    task automatic report_and_stop;
        if (badCount == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    // Main sequence: reset state, every field code, random mix, second reset.
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        seed = 32'h3E430FFE;
        badCount = 0;
        compares = 0;
        ra = 8'h00;
        rd = 8'h00;
        legacyAttackMs = 16'h1234;
        legacyDecayMs = 16'h0321;
        adcDecimationRatio = 4'h2;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        check_all();
        for (int i = 0; i < 32; i++) begin
            apply({1'b1, 5'(i), 2'h0}, {1'b1, 5'(i), 2'h0}, 4'(2 + i % 11));
        end
        apply(8'h00, 8'hFC, 4'h7);
        for (int i = 0; i < 40; i++) begin
            apply(8'($random(seed)), 8'($random(seed)), 4'($random(seed)));
        end
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        ra = 8'h00;
        rd = 8'h00;
        check_all();
        report_and_stop();
    end

    // Watchdog well past the expected run length of about 1050 cycles.
    initial begin
        #(4 * 20000);
        badCount++;
        report_and_stop();
    end
endmodule : rat_agc_time_tb
`default_nettype wire

// File: rat_host_model.sv
`timescale 1ns/1ps
`default_nettype none
//==============================================================
// Host processor that reaches the timing registers.
//==============================================================
module rat_host_model (
    input  wire logic       clk,        // Core clock.
    input  wire logic [7:0] regRdData,  // Read data from the bank.
    output logic      [6:0] regAddr,    // Register address.
    output logic            regWrEn,    // Write strobe.
    output logic      [7:0] regWrData,  // Write data.
    output logic            regRdEn     // Read strobe.
);
    // Strobes idle low from time zero.
    initial begin
        regAddr   = 7'h00;
        regWrEn   = 1'b0;
        regWrData = 8'h00;
        regRdEn   = 1'b0;
    end

    // One write; the lines flip after release so stale values never look valid.
    task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
        @(negedge clk);
        regAddr   = addr;
        regWrData = {data[7:2], 2'h0};
        regWrEn   = 1'b1;
        @(negedge clk);
        regWrEn   = 1'b0;
        regAddr   = ~addr;
        regWrData = ~regWrData;
    endtask : write_reg

    // A write and, in the very next cycle, a read of the same address; the
    // address and data stand through both strobes.
    task automatic write_then_read(input logic [6:0] addr, input logic [7:0] data,
                                   output logic [7:0] rdData);
        @(negedge clk);
        regAddr   = addr;
        regWrData = {data[7:2], 2'h0};
        regWrEn   = 1'b1;
        @(negedge clk);
        regWrEn   = 1'b0;
        regRdEn   = 1'b1;
        @(negedge clk);
        regRdEn   = 1'b0;
        regAddr   = ~addr;
        regWrData = ~regWrData;
        rdData    = regRdData;
    endtask : write_then_read

    // One read; data is taken one edge after the strobe.
    task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
        @(negedge clk);
        regAddr = addr;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        regAddr = ~addr;
        data    = regRdData;
    endtask : read_reg
endmodule : rat_host_model
`default_nettype wire

// File: rat_pkg.sv
//==============================================================
// Shared constants and types for the right-channel AGC timing.
//==============================================================
package rat_pkg;

    //==========================================================
    // Register map of the control-bus page.
    //==========================================================
    localparam logic [6:0] RAT_ADDR_ATTACK = 7'h69;  // Right AGC attack time.
    localparam logic [6:0] RAT_ADDR_DECAY  = 7'h6A;  // Right AGC decay time.
    localparam logic [7:0] RAT_REG_RESET   = 8'h00;  // Both registers clear.
    localparam logic [7:0] RAT_RD_UNMAPPED = 8'h00;  // Other addresses read zero.

    //==========================================================
    // Field positions inside both timing registers.
    //==========================================================
    localparam int RAT_SEL_BIT  = 7;  // Source selection bit.
    localparam int RAT_BASE_LSB = 5;  // Baseline field, bits 6..5.
    localparam int RAT_MULT_LSB = 2;  // Multiplier field, bits 4..2.
    localparam int RAT_RSVD_LSB = 0;  // Reserved field, bits 1..0.

    // Layout of one timing register, most significant field first.
    typedef struct packed {
        logic       select;  // 1 picks this register, 0 the legacy one.
        logic [1:0] base;    // Baseline time code.
        logic [2:0] mult;    // Power-of-two multiplier exponent.
        logic [1:0] rsvd;    // Reserved, software keeps it zero.
    } rat_timing_t;

    //==========================================================
    // Baseline times in milliseconds.
    //==========================================================
    localparam logic [15:0] RAT_ATT_MS_0 = 16'h0007;  // 7 ms.
    localparam logic [15:0] RAT_ATT_MS_1 = 16'h0008;  // 8 ms.
    localparam logic [15:0] RAT_ATT_MS_2 = 16'h000A;  // 10 ms.
    localparam logic [15:0] RAT_ATT_MS_3 = 16'h000B;  // 11 ms.
    localparam logic [15:0] RAT_DEC_MS_0 = 16'h0032;  // 50 ms.
    localparam logic [15:0] RAT_DEC_MS_1 = 16'h0096;  // 150 ms.
    localparam logic [15:0] RAT_DEC_MS_2 = 16'h00FA;  // 250 ms.
    localparam logic [15:0] RAT_DEC_MS_3 = 16'h015E;  // 350 ms.

    //==========================================================
    // Decay caps in milliseconds, by decimation ratio.
    //==========================================================
    localparam logic [15:0] RAT_CAP_R1_0 = 16'h0FA0;  // 4 s.
    localparam logic [15:0] RAT_CAP_R1_5 = 16'h15E0;  // 5.6 s.
    localparam logic [15:0] RAT_CAP_R2_0 = 16'h1F40;  // 8 s.
    localparam logic [15:0] RAT_CAP_R2_5 = 16'h2580;  // 9.6 s.
    localparam logic [15:0] RAT_CAP_R3_0 = 16'h2BC0;  // 11.2 s.
    localparam logic [15:0] RAT_CAP_R4_0 = 16'h3E80;  // 16 s.
    localparam logic [15:0] RAT_CAP_R5_0 = 16'h4B00;  // 19.2 s.
    localparam logic [15:0] RAT_CAP_R5_5 = 16'h5780;  // 22.4 s.
    localparam logic [15:0] RAT_NO_CAP   = 16'hFFFF;  // Attack is never capped.

    // Decimation ratio codes hold twice the ratio, so 1.5 is code 3.
    localparam logic [3:0] RAT_RATIO_1_0 = 4'h2;
    localparam logic [3:0] RAT_RATIO_1_5 = 4'h3;
    localparam logic [3:0] RAT_RATIO_2_0 = 4'h4;
    localparam logic [3:0] RAT_RATIO_2_5 = 4'h5;
    localparam logic [3:0] RAT_RATIO_3_0 = 4'h6;
    localparam logic [3:0] RAT_RATIO_3_5 = 4'h7;
    localparam logic [3:0] RAT_RATIO_4_0 = 4'h8;
    localparam logic [3:0] RAT_RATIO_4_5 = 4'h9;
    localparam logic [3:0] RAT_RATIO_5_0 = 4'hA;

    // Attack baseline lookup.
    function automatic logic [15:0] rat_attack_base(input logic [1:0] code);
        case (code)
            2'h0:    rat_attack_base = RAT_ATT_MS_0;
            2'h1:    rat_attack_base = RAT_ATT_MS_1;
            2'h2:    rat_attack_base = RAT_ATT_MS_2;
            default: rat_attack_base = RAT_ATT_MS_3;
        endcase
    endfunction : rat_attack_base

    // Decay baseline lookup.
    function automatic logic [15:0] rat_decay_base(input logic [1:0] code);
        case (code)
            2'h0:    rat_decay_base = RAT_DEC_MS_0;
            2'h1:    rat_decay_base = RAT_DEC_MS_1;
            2'h2:    rat_decay_base = RAT_DEC_MS_2;
            default: rat_decay_base = RAT_DEC_MS_3;
        endcase
    endfunction : rat_decay_base

    // Decay cap lookup; codes below 2 take the smallest, above 11 the largest.
    function automatic logic [15:0] rat_decay_cap(input logic [3:0] ratio);
        if (ratio <= RAT_RATIO_1_0) begin
            rat_decay_cap = RAT_CAP_R1_0;
        end else if (ratio == RAT_RATIO_1_5) begin
            rat_decay_cap = RAT_CAP_R1_5;
        end else if (ratio == RAT_RATIO_2_0) begin
            rat_decay_cap = RAT_CAP_R2_0;
        end else if (ratio == RAT_RATIO_2_5) begin
            rat_decay_cap = RAT_CAP_R2_5;
        end else if (ratio <= RAT_RATIO_3_5) begin
            rat_decay_cap = RAT_CAP_R3_0;
        end else if (ratio <= RAT_RATIO_4_5) begin
            rat_decay_cap = RAT_CAP_R4_0;
        end else if (ratio == RAT_RATIO_5_0) begin
            rat_decay_cap = RAT_CAP_R5_0;
        end else begin
            rat_decay_cap = RAT_CAP_R5_5;
        end
    endfunction : rat_decay_cap

    // Baseline scaled by two to the multiplier; the largest is 44800 ms.
    function automatic logic [15:0] rat_scale(input logic [15:0] baseMs,
                                              input logic [2:0]  mult);
        rat_scale = baseMs << mult;
    endfunction : rat_scale

endpackage : rat_pkg

// File: rat_time_calc.sv
`timescale 1ns/1ps
`default_nettype none
//==============================================================
// Source selection, scaling and capping for one AGC time.
//==============================================================
module rat_time_calc (
    input  wire logic        select,    // 1 uses the programmed fields.
    input  wire logic [15:0] baseMs,    // Baseline time in ms.
    input  wire logic [2:0]  mult,      // Multiplier exponent.
    input  wire logic [15:0] legacyMs,  // Time from the legacy control register.
    input  wire logic [15:0] capMs,     // Longest time allowed.
    output logic      [15:0] timeMs     // Effective time in ms.
);

    logic [15:0] rawMs;  // Time before the cap.

    // Pick the source, then clamp so the AGC never runs past its limit.
    always_comb begin
        rawMs  = select ? rat_pkg::rat_scale(baseMs, mult) : legacyMs;  // R1 R3 R4 R6
        timeMs = (rawMs > capMs) ? capMs : rawMs;  // R8 R10
    end

endmodule : rat_time_calc
`default_nettype wire
